// ### src/iofr_defines.vh
// Constants for the I/O fault locator and reset block
`ifndef IOFR_DEFINES_VH
`define IOFR_DEFINES_VH

// APB register byte offsets
`define IOFR_OFF_CTRL 8'h00
`define IOFR_OFF_STAT 8'h04
`define IOFR_OFF_LOC 8'h08
`define IOFR_OFF_IRQ_ST 8'h0C
`define IOFR_OFF_IRQ_MASK 8'h10
`define IOFR_OFF_FAULT_IN 8'h14

// Fault-location places, bit position of each place
`define IOFR_PLACE_W 4
`define IOFR_POS_SUPPLY 0
`define IOFR_POS_CH1_IN 4
`define IOFR_POS_CH2_IN 8
`define IOFR_POS_MISC_OUT 16
`define IOFR_POS_CH1_OUT 20
`define IOFR_POS_CH2_OUT 24

// Control register bits
`define IOFR_CTRL_REBOOT 0
`define IOFR_CTRL_DUAL 1

// Interrupt status bits
`define IOFR_IRQ_FAULT 0
`define IOFR_IRQ_CLEARED 1
`define IOFR_IRQ_W 2

// Reset values
`define IOFR_CTRL_RST 32'h0000_0000
`define IOFR_MASK_RST 2'h0

`endif

// ### src/iofr_sync.v
// Three-stage input synchroniser with agreement filter
module iofr_sync #(
  parameter WIDTH = 8
) (
  input wire i_clk,
  input wire i_rst,
  input wire [WIDTH-1:0] i_async,
  output reg [WIDTH-1:0] o_sync
);

  reg [WIDTH-1:0] s1_q;
  reg [WIDTH-1:0] s2_q;
  reg [WIDTH-1:0] s3_q;
  genvar g;

  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      s1_q <= {WIDTH{1'b0}};
      s2_q <= {WIDTH{1'b0}};
      s3_q <= {WIDTH{1'b0}};
    end else begin
      s1_q <= i_async;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // ****************************************
  // Accept a change once stages two and three agree
  // ****************************************
  generate
    for (g = 0; g < WIDTH; g = g + 1) begin : g_bit
      always @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
          o_sync[g] <= 1'b0;
        end else if (s2_q[g] == s3_q[g]) begin
          o_sync[g] <= s3_q[g];
        end
      end
    end
  endgenerate

endmodule

// ### src/iofr_top.v
// I/O fault locator, latch, reset and power-circuit switching
//
// The APB interface to the registers and the register addresses were left to the implementer.
`include "iofr_defines.vh"

module iofr_top (
  input wire i_clk,
  input wire i_rst,
  input wire i_psel,
  input wire i_penable,
  input wire i_pwrite,
  input wire [7:0] i_paddr,
  input wire [31:0] i_pwdata,
  output reg [31:0] o_prdata,
  output wire o_pready,
  output wire o_pslverr,
  input wire i_ch1_fast_off_in_a,
  input wire i_ch1_fast_off_in_b,
  input wire i_ch2_fast_off_in_a,
  input wire i_ch2_fast_off_in_b,
  input wire [3:0] i_place0_fault,
  input wire [3:0] i_place1_fault,
  input wire [3:0] i_place2_fault,
  input wire [3:0] i_place4_fault,
  input wire [3:0] i_place5_fault,
  input wire [3:0] i_place6_fault,
  output reg o_ch1_high_side_out,
  output reg o_ch1_low_side_out,
  output reg o_ch2_high_side_out,
  output reg o_ch2_low_side_out,
  output reg o_ch1_state_out,
  output reg o_ch2_state_out,
  output reg o_fault_signal_out,
  output reg [31:0] o_fault_loc,
  output wire o_irq
);

  // ****************************************
  // Declarations
  // ****************************************
  wire [3:0] fast_s;
  wire [23:0] flt_s;
  reg [3:0] fast_q;
  reg [31:0] loc_q;
  reg [31:0] loc_d;
  reg fault_q;
  reg dual_q;
  reg ch1_on_q;
  reg ch2_on_q;
  reg ch1_armed_q;
  reg ch2_armed_q;
  reg [`IOFR_IRQ_W-1:0] irq_st_q;
  reg [`IOFR_IRQ_W-1:0] irq_mask_q;
  reg reboot_q;
  wire wr_en;
  wire rd_en;
  wire [3:0] fell;
  wire [3:0] rose;
  wire clr_evt;
  wire any_fault;
  wire ch1_pair_flt;
  wire ch2_pair_flt;

  function addr_ok;
    input [7:0] a;
    begin
      addr_ok = (a == `IOFR_OFF_CTRL) || (a == `IOFR_OFF_STAT) ||
        (a == `IOFR_OFF_LOC) || (a == `IOFR_OFF_IRQ_ST) ||
        (a == `IOFR_OFF_IRQ_MASK) || (a == `IOFR_OFF_FAULT_IN);
    end
  endfunction

  // ****************************************
  // Pin synchronisation
  // ****************************************
  iofr_sync #(.WIDTH(4)) u_fast_sync (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_async({i_ch2_fast_off_in_b, i_ch2_fast_off_in_a,
      i_ch1_fast_off_in_b, i_ch1_fast_off_in_a}),
    .o_sync(fast_s)
  );

  iofr_sync #(.WIDTH(24)) u_flt_sync (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_async({i_place6_fault, i_place5_fault, i_place4_fault,
      i_place2_fault, i_place1_fault, i_place0_fault}),
    .o_sync(flt_s)
  );

  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      fast_q <= 4'h0;
    end else begin
      fast_q <= fast_s;
    end
  end

  assign fell = fast_q & ~fast_s;
  assign rose = ~fast_q & fast_s;

  // ****************************************
  // Fault location word
  // ****************************************
  always @* begin
    loc_d = 32'h0000_0000;
    loc_d[`IOFR_POS_SUPPLY +: 4] = {2'b00, flt_s[1:0]};
    loc_d[`IOFR_POS_CH1_IN +: 4] = flt_s[7:4];
    loc_d[`IOFR_POS_CH2_IN +: 4] = flt_s[11:8];
    loc_d[`IOFR_POS_MISC_OUT +: 4] = {1'b0, flt_s[14:12]};
    loc_d[`IOFR_POS_CH1_OUT +: 4] = {1'b0, flt_s[18:16]};
    loc_d[`IOFR_POS_CH2_OUT +: 4] = {1'b0, flt_s[22:20]};
  end

  assign any_fault = |loc_d;
  assign ch1_pair_flt = |loc_d[`IOFR_POS_CH1_IN +: 2];
  assign ch2_pair_flt = |loc_d[`IOFR_POS_CH2_IN +: 2];
  // falling edge on any fast input clears
  // menu reboot also clears, in either mode
  assign clr_evt = (|fell) | reboot_q;

  // ****************************************
  // Fault latch and power circuits
  // ****************************************
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      fault_q <= 1'b0;
      loc_q <= 32'h0000_0000;
      ch1_on_q <= 1'b0;
      ch2_on_q <= 1'b0;
      ch1_armed_q <= 1'b0;
      ch2_armed_q <= 1'b0;
    end else begin
      // latch on any fault, new fault wins
      if (any_fault) begin
        fault_q <= 1'b1;
        loc_q <= loc_q | loc_d;
      end else if (clr_evt) begin
        fault_q <= 1'b0;
        loc_q <= 32'h0000_0000;
      end
      ch1_armed_q <= ~fast_s[0] & ~fast_s[1];
      ch2_armed_q <= ~fast_s[2] & ~fast_s[3];
      // rising edge switches on if clean
      // pair fault drops the channel now
      if (ch1_pair_flt || fault_q || fast_s[1:0] == 2'b00) begin
        ch1_on_q <= 1'b0;
      end else if (|rose[1:0] && (ch1_armed_q || !dual_q)) begin
        ch1_on_q <= 1'b1;
      end
      if (ch2_pair_flt || fault_q || fast_s[3:2] == 2'b00) begin
        ch2_on_q <= 1'b0;
      end else if (|rose[3:2] && (ch2_armed_q || !dual_q)) begin
        ch2_on_q <= 1'b1;
      end
    end
  end

  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_ch1_high_side_out <= 1'b0;
      o_ch1_low_side_out <= 1'b0;
      o_ch2_high_side_out <= 1'b0;
      o_ch2_low_side_out <= 1'b0;
      o_ch1_state_out <= 1'b0;
      o_ch2_state_out <= 1'b0;
      o_fault_signal_out <= 1'b0;
      o_fault_loc <= 32'h0000_0000;
    end else begin
      o_ch1_high_side_out <= ch1_on_q & ~ch1_pair_flt;
      o_ch1_low_side_out <= ch1_on_q & ~ch1_pair_flt;
      o_ch2_high_side_out <= ch2_on_q & ~ch2_pair_flt;
      o_ch2_low_side_out <= ch2_on_q & ~ch2_pair_flt;
      o_ch1_state_out <= ch1_on_q;
      o_ch2_state_out <= ch2_on_q;
      o_fault_signal_out <= fault_q;
      // places 3 and 7 stay zero
      o_fault_loc <= loc_q;
    end
  end

  // ****************************************
  // APB slave and interrupts
  // ****************************************
  assign o_pready = 1'b1;
  assign o_pslverr = i_psel & i_penable & ~addr_ok(i_paddr);
  assign wr_en = i_psel & i_penable & i_pwrite & addr_ok(i_paddr);
  assign rd_en = i_psel & ~i_penable & ~i_pwrite;
  assign o_irq = |(irq_st_q & irq_mask_q);

  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      dual_q <= 1'b0;
      reboot_q <= 1'b0;
      irq_st_q <= {`IOFR_IRQ_W{1'b0}};
      irq_mask_q <= `IOFR_MASK_RST;
      o_prdata <= 32'h0000_0000;
    end else begin
      // menu reboot is a one-cycle command
      reboot_q <= wr_en && i_paddr == `IOFR_OFF_CTRL &&
        i_pwdata[`IOFR_CTRL_REBOOT];
      if (wr_en && i_paddr == `IOFR_OFF_CTRL) begin
        dual_q <= i_pwdata[`IOFR_CTRL_DUAL];
      end
      if (wr_en && i_paddr == `IOFR_OFF_IRQ_MASK) begin
        irq_mask_q <= i_pwdata[`IOFR_IRQ_W-1:0];
      end
      // Set wins over write-one-to-clear
      irq_st_q[`IOFR_IRQ_FAULT] <= (any_fault & ~fault_q) |
        (irq_st_q[`IOFR_IRQ_FAULT] & ~(wr_en &&
        i_paddr == `IOFR_OFF_IRQ_ST && i_pwdata[`IOFR_IRQ_FAULT]));
      irq_st_q[`IOFR_IRQ_CLEARED] <= (fault_q & ~any_fault & clr_evt) |
        (irq_st_q[`IOFR_IRQ_CLEARED] & ~(wr_en &&
        i_paddr == `IOFR_OFF_IRQ_ST && i_pwdata[`IOFR_IRQ_CLEARED]));
      if (rd_en) begin
        case (i_paddr)
          `IOFR_OFF_CTRL: o_prdata <= {30'h0, dual_q, 1'b0};
          `IOFR_OFF_STAT: o_prdata <= {26'h0, ch2_on_q, ch1_on_q,
            fast_s};
          `IOFR_OFF_LOC: o_prdata <= loc_q;
          `IOFR_OFF_IRQ_ST: o_prdata <= {30'h0, irq_st_q};
          `IOFR_OFF_IRQ_MASK: o_prdata <= {30'h0, irq_mask_q};
          `IOFR_OFF_FAULT_IN: o_prdata <= {31'h0, fault_q};
          default: o_prdata <= 32'h0000_0000;
        endcase
      end
    end
  end

endmodule

// ### verification/iofr_chk.sv
// Assertion checker for the fault locator block
module iofr_chk (
  input logic i_clk,
  input logic i_rst,
  input logic i_psel,
  input logic i_pwrite,
  input logic i_ch1_fast_off_in_a,
  input logic i_ch1_fast_off_in_b,
  input logic i_ch2_fast_off_in_a,
  input logic i_ch2_fast_off_in_b,
  input logic [3:0] i_place0_fault,
  input logic [3:0] i_place1_fault,
  input logic o_ch1_high_side_out,
  input logic o_ch1_low_side_out,
  input logic o_ch2_high_side_out,
  input logic o_fault_signal_out,
  input logic [31:0] o_fault_loc
);
  // *****
  // Clear-cause age and properties
  // *****
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);
  logic [3:0] fast_q;
  logic [4:0] age_q;
  wire [3:0] fast = {i_ch2_fast_off_in_b, i_ch2_fast_off_in_a,
    i_ch1_fast_off_in_b, i_ch1_fast_off_in_a};
  // Cycles since a fast input fell or a bus write
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      fast_q <= 4'h0;
      age_q <= 5'h1f;
    end else begin
      fast_q <= fast;
      if ((fast_q & ~fast) != 4'h0 || (i_psel && i_pwrite))
        age_q <= 5'h00;
      else if (age_q != 5'h1f)
        age_q <= age_q + 5'h01;
    end
  end
  sequence s_supply_flt;
    i_place0_fault[0] [*8];
  endsequence
  sequence s_ch1_idle;
    (!i_ch1_fast_off_in_a && !i_ch1_fast_off_in_b) [*8];
  endsequence
  AST_LATCH: assert property (s_supply_flt |-> o_fault_signal_out)
    else $error("fault not latched");
  AST_LOC_MAP: assert property (i_place1_fault[3] [*8] |-> o_fault_loc[7])
    else $error("feedback place wrong");
  AST_LOC_RSVD: assert property ((o_fault_loc & 32'hf888_f00c) == 0)
    else $error("reserved place set");
  AST_HOLD: assert property ($fell(o_fault_signal_out) |-> age_q < 5'h10)
    else $error("fault dropped alone");
  AST_OFF_FAULT: assert property (o_fault_signal_out [*2] |->
    !o_ch1_high_side_out && !o_ch2_high_side_out) else $error("on in fault");
  AST_PAIR_FLT: assert property (i_place1_fault[0] [*8] |->
    !o_ch1_high_side_out) else $error("pair fault kept on");
  AST_IDLE_OFF: assert property (s_ch1_idle |-> !o_ch1_high_side_out)
    else $error("on while inputs low");
  AST_ON_PAIR: assert property (o_ch1_high_side_out == o_ch1_low_side_out)
    else $error("output pair split");
endmodule
bind iofr_top iofr_chk i_chk (.*);

// ### verification/iofr_ctrl_model.sv
// Controller model driving the fast shutdown inputs
module iofr_ctrl_model (
  input wire logic i_clk,
  output logic [3:0] o_fast
);
  timeunit 1ns;
  timeprecision 100ps;
  initial o_fast = 4'h0;
  // Set one channel pair and let it settle
  task put(input int c, input logic [1:0] v);
    o_fast[2 * c +: 2] <= v;
    repeat (12) @(posedge i_clk);
  endtask
  task on(input int c);
    put(c, 2'b00);
    put(c, 2'b11);
  endtask
  task clr(input int c);
    put(c, 2'b01);
    put(c, 2'b00);
  endtask
endmodule

// ### verification/iofr_bench.sv
// Self-checking bench for the fault locator block
`include "iofr_defines.vh"
module iofr_bench;
  timeunit 1ns;
  timeprecision 100ps;
  logic i_clk, i_rst, i_psel, i_penable, i_pwrite, err;
  logic [7:0] i_paddr;
  logic [31:0] i_pwdata, o_prdata, o_fault_loc, rd;
  logic o_pready, o_pslverr, o_irq, o_fault_signal_out;
  logic o_ch1_high_side_out, o_ch1_low_side_out, o_ch1_state_out;
  logic o_ch2_high_side_out, o_ch2_low_side_out, o_ch2_state_out;
  logic [3:0] fast;
  logic [23:0] flt;
  logic [23:0] rin[$];
  logic [31:0] rloc[$];
  int num_errors = 0, checked = 0, cyc = 0;
  int pl[6] = '{0, 1, 2, 4, 5, 6};
  logic [3:0] mk[6] = '{4'h3, 4'hf, 4'hf, 4'h7, 4'h7, 4'h7};
  wire i_ch1_fast_off_in_a = fast[0];
  wire i_ch1_fast_off_in_b = fast[1];
  wire i_ch2_fast_off_in_a = fast[2];
  wire i_ch2_fast_off_in_b = fast[3];
  wire [3:0] i_place0_fault = flt[3:0];
  wire [3:0] i_place1_fault = flt[7:4];
  wire [3:0] i_place2_fault = flt[11:8];
  wire [3:0] i_place4_fault = flt[15:12];
  wire [3:0] i_place5_fault = flt[19:16];
  wire [3:0] i_place6_fault = flt[23:20];
  iofr_top i_iofr_top (.*);
  iofr_ctrl_model i_iofr_ctrl_model (.i_clk(i_clk), .o_fast(fast));
  // *****
  // Tasks
  // *****
  task chk(input string n, input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    i_psel <= 1'b1;
    i_penable <= 1'b0;
    i_pwrite <= w;
    i_paddr <= a;
    i_pwdata <= d;
    @(posedge i_clk);
    i_penable <= 1'b1;
    do @(posedge i_clk); while (o_pready !== 1'b1);
    rd = o_prdata;
    err = o_pslverr;
    i_psel <= 1'b0;
    i_penable <= 1'b0;
    @(posedge i_clk);
  endtask
  task results;
    $display("checked %0d num_errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    i_clk = 1'b0;
    forever #2.5 i_clk = ~i_clk;
  end
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 6000) begin
      num_errors++;
      results();
    end
  end
  // *****
  // Sequence
  // *****
  initial begin
    i_rst = 1'b1;
    i_psel = 1'b0;
    i_penable = 1'b0;
    i_pwrite = 1'b0;
    i_paddr = 8'h00;
    i_pwdata = 32'h0000_0000;
    flt = 24'h00_0000;
    for (int k = 0; k < 6; k++)
      for (int b = 0; b < 4; b++)
        if (mk[k][b]) begin
          rin.push_back(24'h00_0001 << (4 * k + b));
          rloc.push_back(32'h0000_0001 << (4 * pl[k] + b));
        end
    repeat (6) @(posedge i_clk);
    i_rst <= 1'b0;
    repeat (6) @(posedge i_clk);
    chk("sig", o_fault_signal_out, 0);
    chk("loc", o_fault_loc, 0);
    apb(0, `IOFR_OFF_CTRL, 0);
    chk("ctrl", rd, 0);
    apb(0, 8'h18, 0);
    chk("slverr", err, 1);
    $display("reset test done");
    foreach (rin[i]) begin
      flt <= rin[i];
      repeat (10) @(posedge i_clk);
      chk("loc", o_fault_loc, rloc[i]);
      chk("sig", o_fault_signal_out, 1);
      flt <= 24'h00_0000;
      repeat (10) @(posedge i_clk);
      chk("held", o_fault_signal_out, 1);
      i_iofr_ctrl_model.clr(i % 2);
      chk("clr", o_fault_signal_out, 0);
    end
    $display("row test done");
    i_iofr_ctrl_model.on(0);
    chk("on", {o_ch1_high_side_out, o_ch1_low_side_out, o_ch1_state_out},
      7);
    flt <= 24'h00_0010;
    repeat (10) @(posedge i_clk);
    chk("drop", {o_ch1_high_side_out, o_ch1_low_side_out}, 0);
    flt <= 24'h00_0000;
    i_iofr_ctrl_model.clr(0);
    chk("clr", o_fault_signal_out, 0);
    $display("switch test done");
    apb(1, `IOFR_OFF_IRQ_ST, 3);
    apb(1, `IOFR_OFF_IRQ_MASK, 1);
    chk("irq0", o_irq, 0);
    flt <= 24'h00_0002;
    repeat (10) @(posedge i_clk);
    chk("irq", o_irq, 1);
    flt <= 24'h00_0000;
    repeat (10) @(posedge i_clk);
    chk("held", o_fault_signal_out, 1);
    apb(0, `IOFR_OFF_LOC, 0);
    chk("rloc", rd, 32'h0000_0002);
    apb(1, `IOFR_OFF_CTRL, 1);
    repeat (10) @(posedge i_clk);
    chk("reboot", o_fault_signal_out, 0);
    apb(0, `IOFR_OFF_IRQ_ST, 0);
    chk("irqst", rd, 3);
    apb(1, `IOFR_OFF_IRQ_MASK, 0);
    chk("masked", o_irq, 0);
    apb(1, `IOFR_OFF_IRQ_ST, 3);
    apb(0, `IOFR_OFF_IRQ_ST, 0);
    chk("w1c", rd, 0);
    $display("reboot test done");
    apb(1, `IOFR_OFF_CTRL, 2);
    flt <= 24'h00_0100;
    repeat (10) @(posedge i_clk);
    i_iofr_ctrl_model.put(0, 2'b10);
    flt <= 24'h00_0000;
    repeat (10) @(posedge i_clk);
    i_iofr_ctrl_model.clr(1);
    chk("dclr", o_fault_signal_out, 0);
    i_iofr_ctrl_model.put(0, 2'b11);
    chk("dhold", o_ch1_high_side_out, 0);
    i_iofr_ctrl_model.put(0, 2'b00);
    i_iofr_ctrl_model.put(0, 2'b01);
    chk("don", o_ch1_high_side_out, 1);
    apb(0, `IOFR_OFF_STAT, 0);
    chk("stat", rd, 32'h0000_0011);
    i_iofr_ctrl_model.on(1);
    chk("on2", {o_ch2_high_side_out, o_ch2_low_side_out, o_ch2_state_out},
      7);
    apb(0, `IOFR_OFF_STAT, 0);
    chk("stat2", rd, 32'h0000_003d);
    flt <= 24'h00_0200;
    repeat (10) @(posedge i_clk);
    chk("drop2", {o_ch2_high_side_out, o_ch2_low_side_out}, 0);
    chk("loc2", o_fault_loc, 32'h0000_0200);
    flt <= 24'h00_0000;
    i_iofr_ctrl_model.clr(0);
    chk("dclr1", o_fault_signal_out, 0);
    $display("dual test done");
    i_iofr_ctrl_model.put(1, 2'b00);
    flt <= 24'h00_0001;
    repeat (10) @(posedge i_clk);
    flt <= 24'h00_0000;
    apb(0, `IOFR_OFF_FAULT_IN, 0);
    chk("latched", rd, 1);
    i_rst <= 1'b1;
    repeat (6) @(posedge i_clk);
    i_rst <= 1'b0;
    repeat (6) @(posedge i_clk);
    chk("psig", o_fault_signal_out, 0);
    chk("ploc", o_fault_loc, 0);
    apb(0, `IOFR_OFF_CTRL, 0);
    chk("pctrl", rd, 0);
    $display("restart test done");
    results();
  end
endmodule
